/* core/lcd_defines.svh */
// Contract
// - sda falling while scl high is a start condition beginning a transfer.
// - sda rising while scl high is a stop condition ending the transfer.
// - bytes are eight bits msb first, ninth clock is acknowledge, unlimited count.
// - acknowledge holds line low through ninth clock high phase, else released.
// - slave receiver only; the only bus drive is acknowledge.
// - respond only to address 011100 plus strap bit.
// - never acknowledge an address byte requesting a read.
// - matching write address is acknowledged; other strap ignores transfer until start.
// - byte after address is a control byte choosing data or command stream.
// - control and command bytes are always acknowledged once addressed.
// - display bytes acknowledged only when subaddress counter matches hardware pins.
// - display byte stored at pointer, conditioned by subaddress; pointer then advances.
// - command 1100 EBMM sets enable, bias and drive mode.
// - mode bits: 01 static, 10 two-way, 11 three-way, 00 four-way.
// - bias bit 0 selects one-third, 1 selects one-half bias.
// - enable bit 0 blanks display, 1 enables it.
// - command with bit 7 clear loads lower seven bits into pointer.
// - command 11100 AAA loads the subaddress counter.
// - command 111110 I O sets banks; ignored in three- and four-way modes.
// - command 11110 A FF sets blink; alternation ignored in three/four-way.
// - pointer advances 8, 4, 3 or 2 per display byte by mode.
// - subaddress mismatch inhibits storage but pointer advances; overflow bumps subaddress.
// - blink 00 off, 01 2 Hz, 10 1 Hz, 11 0.5 Hz; A selects alternation.
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH

`define LCD_ADDR_FIXED      6'h1c
`define LCD_CTRL_CONT_BIT   7
`define LCD_CTRL_DATA_BIT   6
`define LCD_OP_MODE         4'hc
`define LCD_OP_DEVSEL       5'h1c
`define LCD_OP_BLINK        5'h1e
`define LCD_OP_BANK         6'h3e
`define LCD_RAM_DEPTH       8'h50
`define LCD_INC_STATIC      8'h08
`define LCD_INC_MUX2        8'h04
`define LCD_INC_MUX3        8'h03
`define LCD_INC_MUX4        8'h02
`define LCD_BYTE_LAST_BIT   4'h7
`define LCD_ACK_BIT         4'h8
`define LCD_RST_MODE        2'h0
`define LCD_RST_PTR         7'h00
`define LCD_RST_SUBADDR     3'h0

`endif

/* core/lcd_pkg.sv */
package lcd_pkg;
   typedef enum logic [1:0] {
      LCD_MODE_MUX4   = 2'b00,
      LCD_MODE_STATIC = 2'b01,
      LCD_MODE_MUX2   = 2'b10,
      LCD_MODE_MUX3   = 2'b11
   } lcd_mode_t;

   typedef enum logic [2:0] {
      LCD_ST_IDLE,
      LCD_ST_ADDR,
      LCD_ST_CTRL,
      LCD_ST_DATA,
      LCD_ST_IGNORE
   } lcd_state_t;
endpackage : lcd_pkg

/* core/lcd_i2c_slave_cmd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcd_defines.svh"

module lcd_i2c_slave_cmd_decoder (
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire logic             scl,
   input  wire logic             sda,
   input  wire logic             address_select_strap,
   input  wire logic             hw_subaddr_bit_lo,
   input  wire logic             hw_subaddr_bit_mid,
   input  wire logic             hw_subaddr_bit_hi,
   output logic                  ack_output_pin_out,
   output logic                  ack_output_pin_oe,
   output var lcd_pkg::lcd_mode_t drive_mode,
   output logic                  bias_half,
   output logic                  display_enable,
   output logic [1:0]            blink_freq,
   output logic                  blink_alternate,
   output logic                  input_bank,
   output logic                  output_bank,
   output logic [6:0]            data_pointer,
   output logic [2:0]            subaddr_count,
   output logic                  ram_wr_en,
   output logic [6:0]            ram_wr_addr,
   output logic [7:0]            ram_wr_data,
   output logic                  ram_wr_bank
);
   import lcd_pkg::*;

   // ------------------------------------------------------------
   // link domain: byte shifter clocked by scl
   // ------------------------------------------------------------
   // link_clr comes from a ref_clk flop, so this async clear is glitch free;
   // it is released only while scl is low, away from any scl rising edge
   logic       link_clr;
   wire        link_rst_n = arst_n & ~link_clr;
   logic [3:0] bit_cnt;
   logic [6:0] shift;
   logic [7:0] byte_hold;
   logic       byte_tgl;
   wire        bit_is_data = (bit_cnt < `LCD_ACK_BIT);
   wire        bit_is_last = (bit_cnt == `LCD_BYTE_LAST_BIT);
   wire  [3:0] next_bit_cnt = bit_is_data ? bit_cnt + 4'h1 : 4'h0;

   always_ff @(posedge scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt <= 4'h0;
         shift   <= 7'h00;
      end else begin
         bit_cnt <= next_bit_cnt;
         if (bit_is_data)
            shift <= {shift[5:0], sda};
      end
   end

   // held word survives a restart so the ref side never sees it torn
   always_ff @(posedge scl or negedge arst_n) begin
      if (!arst_n) begin
         byte_hold <= 8'h00;
         byte_tgl  <= 1'b0;
      end else if (bit_is_last && link_rst_n) begin
         byte_hold <= {shift, sda};
         byte_tgl  <= ~byte_tgl;
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic       scl_d;
   logic       sda_d;
   logic [1:0] tgl_meta;
   logic       tgl_sync;
   logic       tgl_d;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta <= 6'h03;
         pin_sync <= 6'h03;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
         tgl_meta <= 2'h0;
         tgl_sync <= 1'b0;
         tgl_d    <= 1'b0;
      end else begin
         pin_meta <= {hw_subaddr_bit_hi, hw_subaddr_bit_mid, hw_subaddr_bit_lo,
                      address_select_strap, sda, scl};
         pin_sync <= pin_meta;
         scl_d    <= pin_sync[0];
         sda_d    <= pin_sync[1];
         tgl_meta <= {tgl_meta[0], byte_tgl};
         tgl_sync <= tgl_meta[1];
         tgl_d    <= tgl_sync;
      end
   end

   wire       scl_s    = pin_sync[0];
   wire       sda_s    = pin_sync[1];
   wire       strap_s  = pin_sync[2];
   wire [2:0] hw_sub_s = pin_sync[5:3];

   // ------------------------------------------------------------
   // start, stop and byte events
   // ------------------------------------------------------------
   wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_seen  = scl_s & scl_d & ~sda_d & sda_s;
   wire scl_fall   = scl_d & ~scl_s;
   wire byte_seen  = (tgl_sync != tgl_d) & ~link_clr;
   wire [7:0] rx   = byte_hold;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   lcd_state_t state;
   lcd_state_t next_state;
   logic       ctrl_cont;
   logic       ctrl_data;
   logic       ack_pend;
   logic       blink_alt_raw;

   wire addr_hit   = (rx[7:2] == `LCD_ADDR_FIXED) & (rx[1] == strap_s);
   wire addr_write = ~rx[0];
   wire sub_match  = (subaddr_count == hw_sub_s);
   wire bank_mode  = (drive_mode == LCD_MODE_STATIC) | (drive_mode == LCD_MODE_MUX2);

   wire in_data    = byte_seen & (state == LCD_ST_DATA);
   wire is_disp    = in_data & ctrl_data;
   wire is_cmd     = in_data & ~ctrl_data;
   wire cmd_ptr    = is_cmd & ~rx[7];
   wire cmd_mode   = is_cmd & (rx[7:4] == `LCD_OP_MODE);
   wire cmd_dev    = is_cmd & (rx[7:3] == `LCD_OP_DEVSEL);
   wire cmd_blink  = is_cmd & (rx[7:3] == `LCD_OP_BLINK);
   wire cmd_bank   = is_cmd & (rx[7:2] == `LCD_OP_BANK);

   wire [7:0] ptr_inc = (drive_mode == LCD_MODE_STATIC) ? `LCD_INC_STATIC :
                        (drive_mode == LCD_MODE_MUX2)   ? `LCD_INC_MUX2   :
                        (drive_mode == LCD_MODE_MUX3)   ? `LCD_INC_MUX3   :
                                                          `LCD_INC_MUX4;
   wire [7:0] ptr_sum  = {1'b0, data_pointer} + ptr_inc;
   wire       ptr_wrap = (ptr_sum >= `LCD_RAM_DEPTH);
   wire [7:0] ptr_wrapped = ptr_sum - `LCD_RAM_DEPTH;
   wire [6:0] next_ptr = ptr_wrap ? ptr_wrapped[6:0] : ptr_sum[6:0];

   logic next_ack;
   always_comb begin
      next_state = state;
      next_ack   = 1'b0;
      if (byte_seen) begin
         case (state)
            LCD_ST_ADDR: begin
               if (addr_hit && addr_write) begin
                  next_state = LCD_ST_CTRL;
                  next_ack   = 1'b1;
               end else begin
                  next_state = LCD_ST_IGNORE;
               end
            end
            LCD_ST_CTRL: begin
               next_state = LCD_ST_DATA;
               next_ack   = 1'b1;
            end
            LCD_ST_DATA: begin
               next_state = ctrl_cont ? LCD_ST_CTRL : LCD_ST_DATA;
               next_ack   = ctrl_data ? sub_match : 1'b1;
            end
            default: next_state = state;
         endcase
      end
      if (start_seen)
         next_state = LCD_ST_ADDR;
      else if (stop_seen)
         next_state = LCD_ST_IDLE;
   end

   // ------------------------------------------------------------
   // protocol state and acknowledge
   // ------------------------------------------------------------
   wire abort = start_seen | stop_seen;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state     <= LCD_ST_IDLE;
         ctrl_cont <= 1'b0;
         ctrl_data <= 1'b0;
         link_clr  <= 1'b1;
      end else begin
         state <= next_state;
         if (byte_seen && state == LCD_ST_CTRL) begin
            ctrl_cont <= rx[`LCD_CTRL_CONT_BIT];
            ctrl_data <= rx[`LCD_CTRL_DATA_BIT];
         end
         if (abort)
            link_clr <= 1'b1;
         else if (!scl_s)
            link_clr <= 1'b0;
      end
   end

   // ack pulls low from the scl fall after the eighth bit to the fall after
   // the ninth; the ref side sees the byte long before that first fall
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_pend           <= 1'b0;
         ack_output_pin_oe  <= 1'b0;
         ack_output_pin_out <= 1'b0;
      end else begin
         ack_output_pin_out <= 1'b0;
         if (abort) begin
            ack_pend          <= 1'b0;
            ack_output_pin_oe <= 1'b0;
         end else if (byte_seen) begin
            ack_pend <= next_ack;
         end else if (scl_fall && ack_output_pin_oe) begin
            ack_output_pin_oe <= 1'b0;
         end else if (scl_fall && ack_pend) begin
            ack_pend          <= 1'b0;
            ack_output_pin_oe <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // configuration, pointer and display writes
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_mode     <= lcd_mode_t'(`LCD_RST_MODE);
         bias_half      <= 1'b0;
         display_enable <= 1'b0;
      end else if (cmd_mode) begin
         display_enable <= rx[3];
         bias_half      <= rx[2];
         drive_mode     <= lcd_mode_t'(rx[1:0]);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         blink_freq    <= 2'h0;
         blink_alt_raw <= 1'b0;
         input_bank    <= 1'b0;
         output_bank   <= 1'b0;
      end else begin
         if (cmd_blink) begin
            blink_freq    <= rx[1:0];
            blink_alt_raw <= rx[2];
         end
         if (cmd_bank && bank_mode) begin
            input_bank  <= rx[1];
            output_bank <= rx[0];
         end
      end
   end

   // alternation is re-qualified each cycle so a later mode change drops it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         blink_alternate <= 1'b0;
      else
         blink_alternate <= blink_alt_raw & bank_mode;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_pointer  <= `LCD_RST_PTR;
         subaddr_count <= `LCD_RST_SUBADDR;
      end else if (cmd_ptr) begin
         data_pointer <= rx[6:0];
      end else if (cmd_dev) begin
         subaddr_count <= rx[2:0];
      end else if (is_disp) begin
         data_pointer <= next_ptr;
         if (ptr_wrap)
            subaddr_count <= subaddr_count + 3'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ram_wr_en   <= 1'b0;
         ram_wr_addr <= 7'h00;
         ram_wr_data <= 8'h00;
         ram_wr_bank <= 1'b0;
      end else begin
         ram_wr_en <= is_disp & sub_match;
         if (is_disp) begin
            ram_wr_addr <= data_pointer;
            ram_wr_data <= rx;
            ram_wr_bank <= input_bank;
         end
      end
   end

endmodule : lcd_i2c_slave_cmd_decoder
`default_nettype wire

/* verification/lcd_i2c_slave_cmd_decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_i2c_slave_cmd_decoder_properties (
   input wire logic               ref_clk,
   input wire logic               arst_n,
   input wire logic               scl,
   input wire logic               hw_subaddr_bit_lo,
   input wire logic               hw_subaddr_bit_mid,
   input wire logic               hw_subaddr_bit_hi,
   input wire logic               ack_output_pin_out,
   input wire logic               ack_output_pin_oe,
   input wire lcd_pkg::lcd_mode_t drive_mode,
   input wire logic               blink_alternate,
   input wire logic               input_bank,
   input wire logic               output_bank,
   input wire logic [6:0]         data_pointer,
   input wire logic [2:0]         subaddr_count,
   input wire logic               ram_wr_en,
   input wire logic [6:0]         ram_wr_addr
);
   import lcd_pkg::*;
   // ----
   // helpers
   // ----
   logic [6:0] prev_ptr;
   logic [2:0] prev_sub;
   logic [7:0] ptr_sum;
   logic [7:0] exp_ptr;
   logic       mux34;
   assign mux34   = drive_mode inside {LCD_MODE_MUX3, LCD_MODE_MUX4};
   assign ptr_sum = {1'b0, prev_ptr} + ((drive_mode == LCD_MODE_STATIC) ? 8'h08 :
                    (drive_mode == LCD_MODE_MUX2) ? 8'h04 :
                    (drive_mode == LCD_MODE_MUX3) ? 8'h03 : 8'h02);
   assign exp_ptr = (ptr_sum >= 8'h50) ? ptr_sum - 8'h50 : ptr_sum;
   // the pointer moves in the same cycle as the write pulse, so keep last cycle's copy
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_ptr <= 7'h00;
         prev_sub <= 3'h0;
      end else begin
         prev_ptr <= data_pointer;
         prev_sub <= subaddr_count;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_ack_low_only: assert property (ack_output_pin_out == 1'b0)
      else $error("ack output drives high");
   a_ack_rise_low: assert property ($rose(ack_output_pin_oe) |-> !scl && !$past(scl, 2))
      else $error("ack started outside scl low");
   a_ack_fall_low: assert property ($fell(ack_output_pin_oe) |-> !scl && !$past(scl, 2))
      else $error("ack released outside scl low");
   a_ack_hold_high: assert property (ack_output_pin_oe && scl |=> ack_output_pin_oe)
      else $error("ack dropped during scl high");
   a_wr_single: assert property (ram_wr_en |=> !ram_wr_en)
      else $error("write pulse longer than one cycle");
   a_wr_old_ptr: assert property (ram_wr_en |-> ram_wr_addr == prev_ptr)
      else $error("write address is not the pointer");
   a_ptr_step: assert property (ram_wr_en |-> data_pointer == exp_ptr[6:0])
      else $error("pointer step wrong for mode");
   a_sub_carry: assert property (ram_wr_en && ptr_sum >= 8'h50 |-> subaddr_count == prev_sub + 3'h1)
      else $error("overflow did not bump subaddress");
   a_wr_match: assert property (ram_wr_en |->
      prev_sub == {hw_subaddr_bit_hi, hw_subaddr_bit_mid, hw_subaddr_bit_lo})
      else $error("write with subaddress mismatch");
   a_alt_masked: assert property (mux34 ##1 mux34 |-> !blink_alternate)
      else $error("alternation shown in mux3 or mux4");
   a_bank_frozen: assert property (mux34 && $past(mux34) |->
      $stable(input_bank) && $stable(output_bank))
      else $error("bank changed in mux3 or mux4");
   a_cfg_scl_high: assert property ($changed(drive_mode) || $changed(subaddr_count) |-> scl)
      else $error("config changed while scl low");
   c_ack: cover property ($rose(ack_output_pin_oe));
   c_wrap: cover property (ram_wr_en && ptr_sum >= 8'h50);
   c_mode: cover property ($changed(drive_mode) && mux34);
endmodule : lcd_i2c_slave_cmd_decoder_properties
bind lcd_i2c_slave_cmd_decoder lcd_i2c_slave_cmd_decoder_properties i_props (
   .ref_clk(ref_clk), .arst_n(arst_n), .scl(scl), .hw_subaddr_bit_lo(hw_subaddr_bit_lo),
   .hw_subaddr_bit_mid(hw_subaddr_bit_mid), .hw_subaddr_bit_hi(hw_subaddr_bit_hi),
   .ack_output_pin_out(ack_output_pin_out), .ack_output_pin_oe(ack_output_pin_oe),
   .drive_mode(drive_mode), .blink_alternate(blink_alternate), .input_bank(input_bank),
   .output_bank(output_bank), .data_pointer(data_pointer), .subaddr_count(subaddr_count),
   .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr));
`default_nettype wire

/* verification/lcd_bus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_bus_master_model (
   output logic     scl,
   output logic     sda_drv,
   input wire logic sda_line
);
   // ----
   // bus phases
   // ----
   // 60 ns phases stay well above the decoder's synchroniser; scl stands high when idle
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic start_cond();
      sda_drv = 1'b1;
      #30 scl = 1'b1;
      #60 sda_drv = 1'b0;
      #60 scl = 1'b0;
      #30;
   endtask : start_cond
   task automatic stop_cond();
      sda_drv = 1'b0;
      #30 scl = 1'b1;
      #60 sda_drv = 1'b1;
      #60;
   endtask : stop_cond
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         sda_drv = b[i];
         #30 scl = 1'b1;
         #60 scl = 1'b0;
         #30;
      end
   endtask : send_bits
   task automatic send_byte(input logic [7:0] b, output logic ack);
      send_bits(b, 8);
      sda_drv = 1'b1;
      #30 scl = 1'b1;
      #30 ack = (sda_line === 1'b0);
      #30 scl = 1'b0;
      #30;
   endtask : send_byte
endmodule : lcd_bus_master_model
`default_nettype wire

/* verification/test_lcd_i2c_slave_cmd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module test_lcd_i2c_slave_cmd_decoder;
   import lcd_pkg::*;
   logic       ref_clk;
   logic       arst_n;
   logic       strap;
   logic [2:0] hw;
   wire        scl;
   wire        sda_drv;
   wire        sda_line;
   wire        ack_out;
   wire        ack_oe;
   lcd_mode_t  mode;
   wire        bias;
   wire        den;
   wire [1:0]  bfreq;
   wire        balt;
   wire        ibank;
   wire        obank;
   wire [6:0]  ptr;
   wire [2:0]  sub;
   wire        wr_en;
   wire [6:0]  wr_addr;
   wire [7:0]  wr_data;
   wire        wr_bank;
   logic       last_bank;
   logic       ack;
   logic [6:0] last_addr;
   logic [7:0] last_data;
   logic [7:0] d;
   int         n_mismatch = 0;
   int         total_checks = 0;
   int         n_wr = 0;
   int         e_wr = 0;
   int         cyc = 0;
   int         p;
   int         s;
   lcd_mode_t  modes [4] = '{LCD_MODE_STATIC, LCD_MODE_MUX2, LCD_MODE_MUX3, LCD_MODE_MUX4};
   int         steps [4] = '{8, 4, 3, 2};
   lcd_bus_master_model i_master (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
   lcd_i2c_slave_cmd_decoder i_dut (
      .ref_clk(ref_clk), .arst_n(arst_n), .scl(scl), .sda(sda_line),
      .address_select_strap(strap), .hw_subaddr_bit_lo(hw[0]), .hw_subaddr_bit_mid(hw[1]),
      .hw_subaddr_bit_hi(hw[2]), .ack_output_pin_out(ack_out), .ack_output_pin_oe(ack_oe),
      .drive_mode(mode), .bias_half(bias), .display_enable(den), .blink_freq(bfreq),
      .blink_alternate(balt), .input_bank(ibank), .output_bank(obank), .data_pointer(ptr),
      .subaddr_count(sub), .ram_wr_en(wr_en), .ram_wr_addr(wr_addr),
      .ram_wr_data(wr_data), .ram_wr_bank(wr_bank));
   // ----
   // wire, clock, monitors
   // ----
   // pull-up line: low while either party pulls it
   assign sda_line = sda_drv & (ack_oe ? ack_out : 1'b1);
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (wr_en === 1'b1) begin
         n_wr      <= n_wr + 1;
         last_addr <= wr_addr;
         last_data <= wr_data;
         last_bank <= wr_bank;
      end
      if (cyc == 40000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic send(input logic [7:0] b, input logic exp_ack);
      i_master.send_byte(b, ack);
      check("ack", {7'h00, ack}, {7'h00, exp_ack});
   endtask : send
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   // ----
   // tests
   // ----
   initial begin
      arst_n = 1'b0;
      strap  = 1'b1;
      hw     = 3'h6;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      check("reset", {1'b0, mode, bias, den, bfreq, balt}, 8'h00);
      i_master.start_cond();
      send(8'h72, 1'b1);
      i_master.stop_cond();
      @(posedge ref_clk) strap <= 1'b0;
      i_master.start_cond();
      send(8'h71, 1'b0);
      i_master.start_cond();
      send(8'h72, 1'b0);
      send(8'h00, 1'b0);
      send(8'hcd, 1'b0);
      i_master.stop_cond();
      check("ignored", {6'h00, mode}, 8'h00);
      $display("test address done");
      i_master.start_cond();
      send(8'h70, 1'b1);
      send(8'h00, 1'b1);
      for (int m = 0; m < 4; m++) begin
         send({4'hc, m[0], m[1], m[1:0]}, 1'b1);
         check("mode", {4'h0, den, bias, mode}, {4'h0, m[0], m[1], m[1:0]});
      end
      send(8'hc9, 1'b1);
      for (int f = 0; f < 4; f++) begin
         send({5'h1e, f[0], f[1:0]}, 1'b1);
         check("blink", {5'h00, balt, bfreq}, {5'h00, f[0], f[1:0]});
      end
      send(8'hfa, 1'b1);
      check("bank", {6'h00, ibank, obank}, 8'h02);
      send(8'hcb, 1'b1);
      send(8'hf5, 1'b1);
      send(8'hf9, 1'b1);
      check("mux3", {5'h00, ibank, obank, balt}, 8'h04);
      send(8'he5, 1'b1);
      send(8'h4e, 1'b1);
      check("sub", {5'h00, sub}, 8'h05);
      i_master.send_bits(8'hc1, 4);
      i_master.stop_cond();
      check("abort", {mode, ptr[5:0]}, {LCD_MODE_MUX3, 6'h0e});
      $display("test command done");
      for (int k = 0; k < 4; k++) begin
         i_master.start_cond();
         send(8'h70, 1'b1);
         send(8'h80, 1'b1);
         send({5'h1c, hw}, 1'b1);
         send(8'h80, 1'b1);
         send(8'h4d, 1'b1);
         send(8'h80, 1'b1);
         send({6'h32, modes[k]}, 1'b1);
         send(8'h40, 1'b1);
         p = 77;
         s = hw;
         for (int j = 0; j < 2; j++) begin
            d = 8'(8'h5a + k + j);
            send(d, s == hw);
            if (s == hw) begin
               e_wr++;
               check("waddr", {1'b0, last_addr}, 8'(p));
               check("wdata", last_data, d);
               check("wbank", {7'h00, last_bank}, 8'h01);
            end
            p = p + steps[k];
            if (p >= 80) begin
               p = p - 80;
               s = s + 1;
            end
            check("writes", n_wr[7:0], e_wr[7:0]);
            check("ptr", {1'b0, ptr}, 8'(p));
            check("sub", {5'h00, sub}, 8'(s));
         end
         i_master.stop_cond();
      end
      $display("test display done");
      conclude();
   end
endmodule : test_lcd_i2c_slave_cmd_decoder
`default_nettype wire
